// ===== verilog/mmap_decoder.sv
// Memory space decoder: program regions, data map, bit access and stack
`timescale 1ns/100ps
module mmap_decoder (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    // Program fetch side
    input  wire logic             i_irq_entry,
    input  wire logic [3:0]       i_irq_vec,
    input  wire logic             i_zp_call,
    input  wire logic [5:0]       i_zp_target,
    input  wire logic             i_pat_fetch,
    input  wire logic [13:0]      i_pat_addr,
    output logic                  o_vec_load,
    output logic      [13:0]      o_vec_addr,
    output logic      [13:0]      o_zp_addr,
    output logic                  o_pat_ok,
    output logic      [13:0]      o_pat_rom_addr,
    // Data access side
    input  wire mmap_pkg::mmap_op_t i_op,
    input  wire logic [9:0]       i_addr,
    input  wire logic [1:0]       i_bit,
    input  wire logic [3:0]       i_wdata,
    input  wire logic             i_memreg_op,
    input  wire logic [3:0]       i_memreg_idx,
    output logic      [3:0]       o_rdata,
    output logic                  o_test_bit,
    output logic                  o_access_err,
    output logic      [11:0]      o_ram_addr,
    output logic                  o_ram_sel,
    input  wire logic [3:0]       i_ram_rdata,
    // Ports
    input  wire logic [11:0]      i_bitport_in,
    output logic      [11:0]      o_bitport_out,
    input  wire logic [3:0]       i_nibport_in,
    output logic      [3:0]       o_nibport_out,
    // Power state
    input  wire logic             i_stop_req,
    input  wire logic [3:0]       i_wakeup_input_n,
    output logic                  o_stopped,
    // Register outputs to peripherals
    output logic      [3:0]       o_display_control,
    output logic      [3:0]       o_buzzer_mode,
    output logic      [3:0]       o_bank,
    output logic      [3:0]       o_flags
);

    localparam logic [9:0] BITPORT_ADDR = 10'h070;
    localparam logic [9:0] NIBPORT_ADDR = 10'h080;

    logic [3:0] icb [4];
    logic [3:0] flags;
    logic [3:0] display_control;
    logic [3:0] buzzer_mode;
    logic [3:0] bank;
    logic       stopped;
    logic [3:0] next_rdata;
    logic       next_err;
    logic       next_test;
    logic       is_bitop;
    logic       in_regs;
    logic [9:0] eff_addr;
    logic       is_bitport;
    logic       in_stack;

    assign is_bitop = (i_op == mmap_pkg::OP_BSET) ||
                      (i_op == mmap_pkg::OP_BCLR) ||
                      (i_op == mmap_pkg::OP_BTEST);
    // Memory register instructions address the 16 digits by index
    assign eff_addr = i_memreg_op ?
                      (mmap_pkg::MREG_LO | {6'h00, i_memreg_idx}) :
                      i_addr;
    assign in_regs  = (eff_addr <= mmap_pkg::REGS_HI);
    // Bit port spans three digits; the fourth would index past pin 11
    assign is_bitport = (eff_addr >= BITPORT_ADDR) &&
                        (eff_addr <= BITPORT_ADDR + 10'h002);
    // Stack is plain RAM: 16 levels of 4 digits up to the top of data space
    assign in_stack = (eff_addr >= mmap_pkg::STACK_LO);

    // Vector and program-region address generation
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_vec_load <= 1'b1;
            o_vec_addr <= mmap_pkg::RESET_VEC;
        end else begin
            o_vec_load <= i_irq_entry;
            o_vec_addr <= mmap_pkg::VEC_LO | {10'h000, i_irq_vec};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_zp_addr      <= mmap_pkg::VEC_LO;
            o_pat_ok       <= 1'b0;
            o_pat_rom_addr <= mmap_pkg::VEC_LO;
        end else begin
            if (i_zp_call) begin
                o_zp_addr <= {8'h00, i_zp_target} & mmap_pkg::ZP_HI;
            end
            o_pat_ok  <= i_pat_fetch && (i_pat_addr <= mmap_pkg::PAT_HI);
            o_pat_rom_addr <= i_pat_addr & mmap_pkg::PAT_HI;
        end
    end

    // RAM address: banked area gets the bank as high bits, registers never go to RAM
    always_comb begin
        o_ram_sel  = 1'b0;
        o_ram_addr = {2'b00, eff_addr};
        if (!in_regs && (i_op != mmap_pkg::OP_NONE) &&
            !is_bitport && eff_addr != NIBPORT_ADDR) begin
            o_ram_sel = 1'b1;
            if (eff_addr >= mmap_pkg::BANKED_LO &&
                eff_addr <= mmap_pkg::BANKED_HI) begin
                o_ram_addr = {bank[1:0], eff_addr};
            end
        end
    end

    // Read and test path with per-region access checks
    always_comb begin
        next_rdata = 4'h0;
        next_err   = 1'b0;
        next_test  = 1'b0;
        if (eff_addr <= mmap_pkg::ICB_HI) begin
            next_err  = !is_bitop && (i_op != mmap_pkg::OP_NONE);
            next_test = icb[eff_addr[1:0]][i_bit];
        end else if (eff_addr >= mmap_pkg::RFL_LO &&
                     eff_addr <= mmap_pkg::RFL_HI) begin
            next_err  = !is_bitop && (i_op != mmap_pkg::OP_NONE);
            next_test = (eff_addr == mmap_pkg::RFL_LO) && flags[i_bit];
        end else if (in_regs) begin
            if (is_bitop) begin
                next_err = !((eff_addr == mmap_pkg::DISP_CTRL) ||
                    (eff_addr == mmap_pkg::BUZZ_MODE && i_bit == 2'd3)) ||
                    (i_op == mmap_pkg::OP_BTEST);
            end
            case (eff_addr)
                mmap_pkg::DISP_CTRL: next_rdata = display_control;
                mmap_pkg::BUZZ_MODE: next_rdata = buzzer_mode;
                mmap_pkg::BANK_REG:  next_rdata = bank;
                default:             next_rdata = 4'h0;
            endcase
        end else if (is_bitport) begin
            next_err  = (i_op == mmap_pkg::OP_READ) ||
                        (i_op == mmap_pkg::OP_WRITE);
            next_test = i_bitport_in[{eff_addr[1:0], i_bit}];
        end else if (eff_addr == NIBPORT_ADDR) begin
            next_err   = is_bitop;
            next_rdata = i_nibport_in;
        end else begin
            next_rdata = i_ram_rdata;
            next_test  = i_ram_rdata[i_bit];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_rdata      <= mmap_pkg::DIGIT_RST;
            o_test_bit   <= 1'b0;
            o_access_err <= 1'b0;
        end else begin
            o_rdata      <= next_rdata;
            o_test_bit   <= next_test;
            o_access_err <= next_err;
        end
    end

    // Interrupt control bits: only bit set and clear change them
    generate
        for (genvar g = 0; g < 4; g++) begin : g_icb
            always_ff @(posedge i_core_clk) begin
                if (!i_nrst) begin
                    icb[g] <= mmap_pkg::DIGIT_RST;
                end else if (eff_addr == 10'(g)) begin
                    if (i_op == mmap_pkg::OP_BSET) begin
                        icb[g][i_bit] <= 1'b1;
                    end else if (i_op == mmap_pkg::OP_BCLR) begin
                        icb[g][i_bit] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Register flags; the subactive flag cannot be set while active
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            flags <= mmap_pkg::DIGIT_RST;
        end else if (eff_addr == mmap_pkg::RFL_LO) begin
            if (i_op == mmap_pkg::OP_BSET &&
                i_bit != 2'(mmap_pkg::SUBACT_BIT)) begin
                flags[i_bit] <= 1'b1;
            end else if (i_op == mmap_pkg::OP_BCLR &&
                         i_bit != 2'(mmap_pkg::WDOG_BIT)) begin
                flags[i_bit] <= 1'b0;
            end
        end
    end

    // Special registers and bit port write path
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            display_control <= mmap_pkg::DIGIT_RST;
            buzzer_mode     <= mmap_pkg::DIGIT_RST;
            bank            <= mmap_pkg::DIGIT_RST;
            o_bitport_out   <= 12'h000;
            o_nibport_out   <= 4'h0;
        end else begin
            case (i_op)
                mmap_pkg::OP_WRITE: begin
                    if (eff_addr == mmap_pkg::DISP_CTRL)
                        display_control <= i_wdata;
                    if (eff_addr == mmap_pkg::BUZZ_MODE)
                        buzzer_mode <= i_wdata;
                    if (eff_addr == mmap_pkg::BANK_REG)
                        bank <= i_wdata;
                    if (eff_addr == NIBPORT_ADDR)
                        o_nibport_out <= i_wdata;
                end
                mmap_pkg::OP_BSET, mmap_pkg::OP_BCLR: begin
                    if (eff_addr == mmap_pkg::DISP_CTRL)
                        display_control[i_bit] <=
                            (i_op == mmap_pkg::OP_BSET);
                    if (eff_addr == mmap_pkg::BUZZ_MODE && i_bit == 2'd3)
                        buzzer_mode[3] <= (i_op == mmap_pkg::OP_BSET);
                    if (is_bitport)
                        o_bitport_out[{eff_addr[1:0], i_bit}] <=
                            (i_op == mmap_pkg::OP_BSET);
                end
                default: begin
                end
            endcase
        end
    end

    // Stop mode; any low wakeup input returns to active
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            stopped <= 1'b0;
        end else if (stopped && (i_wakeup_input_n != 4'hf)) begin
            stopped <= 1'b0;
        end else if (i_stop_req) begin
            stopped <= 1'b1;
        end
    end

    assign o_stopped         = stopped;
    assign o_display_control = display_control;
    assign o_buzzer_mode     = buzzer_mode;
    assign o_bank            = bank;
    assign o_flags           = flags;

    a_reset_vector: assert property (@(posedge i_core_clk)
        !i_nrst |=> o_vec_load && o_vec_addr == 14'h0000)
        else $error("reset vector not loaded");
    a_vector_range: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) o_vec_load |-> o_vec_addr <= 14'h000f)
        else $error("vector outside vector area");
    a_zp_range: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) o_zp_addr <= 14'h003f)
        else $error("zero page target out of range");
    a_pat_refuse: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) i_pat_fetch && i_pat_addr > 14'h0fff
        |=> !o_pat_ok) else $error("pattern fetch beyond range");
    a_regs_no_ram: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) in_regs |-> !o_ram_sel)
        else $error("register address reached RAM");
    a_icb_bitonly: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) eff_addr <= 10'h003 &&
        i_op == mmap_pkg::OP_WRITE |=> $stable(icb[0]) && o_access_err)
        else $error("interrupt bits changed by plain write");
    a_wdog_sticky: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) flags[1] |=> flags[1])
        else $error("watchdog flag cleared");
    a_bank_map: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) o_ram_sel && eff_addr >= 10'h090 &&
        eff_addr <= 10'h25f |-> o_ram_addr[11:10] == bank[1:0])
        else $error("banked address ignores bank");
    a_wakeup_exit: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) stopped && i_wakeup_input_n != 4'hf
        |=> !stopped) else $error("wakeup did not leave stop");
    a_stack_ram: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) in_stack && i_op == mmap_pkg::OP_READ
        |-> o_ram_sel && o_ram_addr == {2'b00, eff_addr})
        else $error("stack digit not mapped to RAM");
    a_bitport_noram: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst) is_bitport |-> !o_ram_sel)
        else $error("bit port access reached RAM");

endmodule

// ===== verilog/mmap_pkg.sv
// Address map constants for the memory space decoder
package mmap_pkg;
    // Program space
    localparam logic [13:0] VEC_LO       = 14'h0000;
    localparam logic [13:0] VEC_HI       = 14'h000f;
    localparam logic [13:0] ZP_HI        = 14'h003f;
    localparam logic [13:0] PAT_HI       = 14'h0fff;
    localparam logic [13:0] RESET_VEC    = 14'h0000;
    // Data space
    localparam logic [9:0]  ICB_LO       = 10'h000;
    localparam logic [9:0]  ICB_HI       = 10'h003;
    localparam logic [9:0]  SFR1_HI      = 10'h01f;
    localparam logic [9:0]  RFL_LO       = 10'h020;
    localparam logic [9:0]  RFL_HI       = 10'h023;
    localparam logic [9:0]  REGS_HI      = 10'h03f;
    localparam logic [9:0]  DISP_CTRL    = 10'h02c;
    localparam logic [9:0]  BUZZ_MODE    = 10'h02e;
    localparam logic [9:0]  BANK_REG     = 10'h03f;
    localparam logic [9:0]  MREG_LO      = 10'h040;
    localparam logic [9:0]  MREG_HI      = 10'h04f;
    localparam logic [9:0]  BANKED_LO    = 10'h090;
    localparam logic [9:0]  BANKED_HI    = 10'h25f;
    localparam logic [9:0]  STACK_LO     = 10'h3c0;
    localparam int          STACK_LEVELS = 16;
    localparam int          STACK_DIGITS = 4;
    // Register flag bit positions at 0x020
    localparam int          SUBACT_BIT   = 3;
    localparam int          WDOG_BIT     = 1;
    // Reset values
    localparam logic [3:0]  DIGIT_RST    = 4'h0;
    // Operation codes from the execution unit
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_READ  = 3'b001,
        OP_WRITE = 3'b010,
        OP_BSET  = 3'b011,
        OP_BCLR  = 3'b100,
        OP_BTEST = 3'b101
    } mmap_op_t;
endpackage

// ===== sim/mmap_ram_model.sv
// Behavioural data RAM standing behind the decoder's RAM select
`timescale 1ns/100ps
module mmap_ram_model (
    // Clock
    input  wire logic        i_core_clk,
    // Decoder side
    input  wire logic        i_sel,
    input  wire logic [11:0] i_addr,
    output logic      [3:0]  o_rdata
);
    logic [3:0] last_q = 4'h0;

    // Never cleared: each digit shows its own bank and address pattern
    always_comb begin
        if (i_sel)
            o_rdata = i_addr[3:0] ^ i_addr[7:4] ^ i_addr[11:8];
        else
            o_rdata = ~last_q;
    end

    // Deselected bus shows the inverse, so a stale capture cannot match
    always_ff @(posedge i_core_clk) begin
        if (i_sel)
            last_q <= o_rdata;
    end
endmodule

// ===== sim/tb.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/100ps
module tb;
    localparam mmap_pkg::mmap_op_t RD = mmap_pkg::OP_READ;
    localparam mmap_pkg::mmap_op_t WR = mmap_pkg::OP_WRITE;
    localparam mmap_pkg::mmap_op_t BS = mmap_pkg::OP_BSET;
    localparam mmap_pkg::mmap_op_t BC = mmap_pkg::OP_BCLR;
    localparam mmap_pkg::mmap_op_t BT = mmap_pkg::OP_BTEST;
    logic               i_core_clk, o_vec_load, o_pat_ok, o_test_bit;
    logic               o_access_err, o_ram_sel, o_stopped, rs_q;
    logic               i_nrst = 1'b0, i_irq_entry = 1'b0, i_zp_call = 1'b0;
    logic               i_pat_fetch = 1'b0, i_memreg_op = 1'b0;
    logic               i_stop_req = 1'b0;
    logic [1:0]         i_bit = 2'h0;
    logic [3:0]         i_irq_vec = 4'h0, i_wdata = 4'h0, i_memreg_idx = 4'h0;
    logic [3:0]         i_nibport_in = 4'h9, i_wakeup_input_n = 4'hf;
    logic [3:0]         i_ram_rdata, o_rdata, o_nibport_out, o_bank, o_flags;
    logic [3:0]         o_display_control, o_buzzer_mode;
    logic [5:0]         i_zp_target = 6'h0;
    logic [9:0]         i_addr = 10'h0;
    logic [11:0]        i_bitport_in = 12'h5a5, o_ram_addr, o_bitport_out, ra_q;
    logic [13:0]        i_pat_addr = 14'h0, o_vec_addr, o_zp_addr;
    logic [13:0]        o_pat_rom_addr;
    logic [13:0]        pv [9];
    mmap_pkg::mmap_op_t i_op = mmap_pkg::OP_NONE;
    int                 mismatches = 0;
    int                 num_checks = 0;
    string              pn [9] = '{"err", "tbit", "disp", "buzz", "flags",
                                   "rdata", "bank", "bitport", "nibport"};

    mmap_decoder u_dut (
        .i_core_clk, .i_nrst, .i_irq_entry, .i_irq_vec, .i_zp_call,
        .i_zp_target, .i_pat_fetch, .i_pat_addr, .o_vec_load, .o_vec_addr,
        .o_zp_addr, .o_pat_ok, .o_pat_rom_addr, .i_op, .i_addr, .i_bit,
        .i_wdata, .i_memreg_op, .i_memreg_idx, .o_rdata, .o_test_bit,
        .o_access_err, .o_ram_addr, .o_ram_sel, .i_ram_rdata, .i_bitport_in,
        .o_bitport_out, .i_nibport_in, .o_nibport_out, .i_stop_req,
        .i_wakeup_input_n, .o_stopped, .o_display_control, .o_buzzer_mode,
        .o_bank, .o_flags
    );
    mmap_ram_model u_ram (
        .i_core_clk, .i_sel(o_ram_sel), .i_addr(o_ram_addr),
        .o_rdata(i_ram_rdata)
    );
    assign pv = '{{13'h0, o_access_err}, {13'h0, o_test_bit},
                  {10'h0, o_display_control}, {10'h0, o_buzzer_mode},
                  {10'h0, o_flags}, {10'h0, o_rdata}, {10'h0, o_bank},
                  {2'h0, o_bitport_out}, {10'h0, o_nibport_out}};

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input string n, input logic [13:0] s, e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Request stands one cycle; the RAM select is combinational, so catch it
    task automatic op(input mmap_pkg::mmap_op_t o, input logic [9:0] a,
                      input logic [1:0] b, input logic [3:0] d);
        @(posedge i_core_clk);
        i_op <= o;
        i_addr <= a;
        i_bit <= b;
        i_wdata <= d;
        #1;
        ra_q = o_ram_addr;
        rs_q = o_ram_sel;
        @(posedge i_core_clk);
        i_op <= mmap_pkg::OP_NONE;
        #1;
    endtask

    task automatic row(input mmap_pkg::mmap_op_t o, input logic [9:0] a,
                       input logic [1:0] b, input logic [3:0] d,
                       input int p, input logic [13:0] e);
        op(o, a, b, d);
        chk(pn[p], pv[p], e);
    endtask

    task automatic rd(input logic [9:0] a, input logic [11:0] e);
        op(RD, a, 2'h0, 4'h0);
        chk("ram_addr", {2'h0, ra_q}, {2'h0, e});
        chk("ram_sel", {13'h0, rs_q}, 14'h1);
        chk("rdata", {10'h0, o_rdata}, {10'h0, e[3:0] ^ e[7:4] ^ e[11:8]});
    endtask

    task automatic t_prog;
        int k;
        for (k = 0; k < 3 && o_vec_load !== 1'b1; k++) begin
            @(posedge i_core_clk);
            #1;
        end
        chk("reset_vec", {13'h0, o_vec_load}, 14'h1);
        // Program keeps a long jump in each slot; only the slot is checked
        chk("reset_addr", o_vec_addr, 14'h0000);
        @(posedge i_core_clk);
        i_irq_entry <= 1'b1;
        i_irq_vec <= 4'hf;
        i_zp_call <= 1'b1;
        i_zp_target <= 6'h3f;
        @(posedge i_core_clk);
        i_irq_entry <= 1'b0;
        i_zp_call <= 1'b0;
        #1;
        chk("irq_vec", {13'h0, o_vec_load}, 14'h1);
        chk("irq_addr", o_vec_addr, 14'h000f);
        chk("zp_addr", o_zp_addr, 14'h003f);
        for (k = 0; k < 2; k++) begin
            @(posedge i_core_clk);
            i_pat_fetch <= 1'b1;
            i_pat_addr <= (k == 1) ? 14'h1000 : 14'h0fff;
            @(posedge i_core_clk);
            i_pat_fetch <= 1'b0;
            #1;
            chk("pat_ok", {13'h0, o_pat_ok}, {13'h0, k == 0});
            if (k == 0)
                chk("pat_rom", o_pat_rom_addr, 14'h0fff);
        end
    endtask

    task automatic t_data;
        row(WR, 10'h03f, 2'h0, 4'h2, 6, 14'h2);
        rd(10'h100, 12'h900);
        rd(10'h300, 12'h300);
        rd(10'h3ff, 12'h3ff);
        rd(10'h045, 12'h045);
        @(posedge i_core_clk);
        i_memreg_op <= 1'b1;
        i_memreg_idx <= 4'hf;
        rd(10'h000, 12'h04f);
        i_memreg_op <= 1'b0;
        op(RD, 10'h010, 2'h0, 4'h0);
        chk("reg_ram_sel", {13'h0, rs_q}, 14'h0);
    endtask

    task automatic t_regs;
        row(RD, 10'h000, 2'h0, 4'h0, 0, 14'h1);
        row(WR, 10'h002, 2'h0, 4'hf, 0, 14'h1);
        row(WR, 10'h021, 2'h0, 4'hf, 0, 14'h1);
        row(BS, 10'h001, 2'h2, 4'h0, 0, 14'h0);
        row(BT, 10'h001, 2'h2, 4'h0, 1, 14'h1);
        row(BC, 10'h001, 2'h2, 4'h0, 0, 14'h0);
        row(BT, 10'h001, 2'h2, 4'h0, 1, 14'h0);
        row(BS, 10'h020, 2'h1, 4'h0, 4, 14'h2);
        row(BC, 10'h020, 2'h1, 4'h0, 4, 14'h2);
        row(BS, 10'h020, 2'h3, 4'h0, 4, 14'h2);
        row(WR, 10'h02c, 2'h0, 4'h5, 2, 14'h5);
        row(BS, 10'h02c, 2'h1, 4'h0, 2, 14'h7);
        row(BC, 10'h02c, 2'h0, 4'h0, 2, 14'h6);
        row(RD, 10'h02c, 2'h0, 4'h0, 5, 14'h6);
        row(BT, 10'h02c, 2'h0, 4'h0, 0, 14'h1);
        row(BS, 10'h02e, 2'h3, 4'h0, 3, 14'h8);
        row(BS, 10'h02e, 2'h0, 4'h0, 0, 14'h1);
        row(BS, 10'h004, 2'h0, 4'h0, 0, 14'h1);
        row(BS, 10'h070, 2'h2, 4'h0, 7, 14'h004);
        row(BS, 10'h072, 2'h3, 4'h0, 7, 14'h804);
        row(WR, 10'h070, 2'h0, 4'hf, 0, 14'h1);
        row(WR, 10'h080, 2'h0, 4'ha, 8, 14'ha);
        row(BS, 10'h080, 2'h0, 4'h0, 0, 14'h1);
        row(BT, 10'h070, 2'h0, 4'h0, 1, 14'h1);
        row(BT, 10'h071, 2'h2, 4'h0, 1, 14'h0);
        row(RD, 10'h080, 2'h0, 4'h0, 5, 14'h9);
    endtask

    task automatic t_stop;
        int w;
        for (w = 0; w < 4; w++) begin
            @(posedge i_core_clk);
            i_stop_req <= 1'b1;
            @(posedge i_core_clk);
            i_stop_req <= 1'b0;
            #1;
            chk("stopped", {13'h0, o_stopped}, 14'h1);
            @(posedge i_core_clk);
            i_wakeup_input_n <= ~(4'h1 << w);
            @(posedge i_core_clk);
            i_wakeup_input_n <= 4'hf;
            #1;
            chk("woken", {13'h0, o_stopped}, 14'h0);
        end
    endtask

    // Hang guard at 50000 cycles, far above the length of the test run
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_prog();
        t_data();
        t_regs();
        t_stop();
        summarize();
    end
endmodule
